/* rtl/pin_edge_sync.sv */
// Two-flop synchroniser followed by an edge detector on the second stage.
module pin_edge_sync #(
	parameter logic RST_LEVEL = 1'b1
) (
	// Clock and reset.
	input  wire logic                       i_clk,
	input  wire logic                       i_rst,
	// Asynchronous pin and its synchronised view.
	input  wire logic                       i_pin,
	output sar_port_pkg::pin_sample_t       o_pin
);

	logic meta_q;
	logic sync_q;
	logic last_q;

	// The first stage feeds only the second; edges are taken further down.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_q <= RST_LEVEL;
			sync_q <= RST_LEVEL;
			last_q <= RST_LEVEL;
		end else begin
			meta_q <= i_pin;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	// Edge pulses last exactly one core cycle.
	assign o_pin.level = sync_q;
	assign o_pin.rise  = sync_q & ~last_q;
	assign o_pin.fall  = ~sync_q & last_q;

endmodule : pin_edge_sync

/* rtl/sar_port_consts.svh */
`ifndef SAR_PORT_CONSTS_SVH
`define SAR_PORT_CONSTS_SVH

// Result and frame geometry.
`define CONV_BITS        14
`define FRAME_EDGES      16
`define LAST_CONV_EDGE   14
`define EDGE_CNT_W       5

// Select pulses with a static shift clock that enter each power-down mode.
`define NAP_PULSES       3'h2
`define SLEEP_PULSES     3'h4

// Core clock period and the wake-up times, each in its own unit.
`define CORE_PERIOD_NS   50
`define WAKE_NAP_NS      50
`define WAKE_SLEEP_MS    1.1

// Least waits round up to whole core cycles.
`define WAKE_NAP_CYC     ((`WAKE_NAP_NS + `CORE_PERIOD_NS - 1) / \
                          `CORE_PERIOD_NS)
`define WAKE_SLEEP_CYC   $rtoi(((`WAKE_SLEEP_MS * 1000000.0) + \
                          `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)

// Reset values.
`define RESULT_RST       14'h0000

`endif

/* rtl/sar_port_pkg.sv */
package sar_port_pkg;

	// Power state of the converter core.
	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'b00,
		PWR_NAP    = 2'b01,
		PWR_SLEEP  = 2'b10
	} pwr_state_t;

	// A synchronised pin with its edge pulses.
	typedef struct packed {
		logic level;
		logic rise;
		logic fall;
	} pin_sample_t;

endpackage : sar_port_pkg

/* rtl/sar_readout_port.sv */
// How it works
// RQ1: A falling frame select starts a conversion and one result transfer.
// RQ2: A rising frame select puts the front end back into tracking.
// RQ3: The serial output stays undriven while frame select is high.
// RQ4: Shift-clock falls 1 to 14 step the conversion and falls 1 to 16 the output, MSB first.
// RQ5: The output changes only on shift-clock falls; host samples it stable.
// RQ6: Free-running or burst shift clocks both work; the port only sees edges.
// RQ7: Each frame shifts out the result of the last completed frame's sample.
// RQ8: After the sixteenth shift-clock fall the output is released.
// RQ9: Host holds select low past the fourteenth fall, else it aborts.
// RQ10: After nap exit the host waits about 50 ns before trusting results.
// RQ11: After sleep exit the host waits about 1.1 ms before trusting results.
// RQ12: One or two leading zeros, set by idle clock level, then 14 bits.
// RQ13: Shift-clock falls after the LSB shift out zeros up to the sixteenth, which releases the line.
// RQ14: Two select pulses with a static shift clock enter nap.
// RQ15: Four select pulses with a static shift clock enter sleep.
// RQ16: Host counts falls and keeps the 14 data bits only.
// RQ17: Host drops the first result after power-down exit or an abort.
`include "sar_port_consts.svh"

module sar_readout_port #(
	parameter int CONV_W         = `CONV_BITS,
	parameter int WAKE_SLEEP_CYC = `WAKE_SLEEP_CYC,
	parameter int WAKE_NAP_CYC   = `WAKE_NAP_CYC
) (
	// Core clock and reset.
	input  wire logic              I_CORE_CLK,
	input  wire logic              I_RST,
	// Serial port pins from the host.
	input  wire logic              I_FRAME_SEL_N,
	input  wire logic              I_SHIFT_CLK,
	// Held sample code from the front end, core clock domain.
	input  wire logic [CONV_W-1:0] I_SAMPLE_CODE,
	// Serial result pin as data and output enable.
	output wire logic              O_SERIAL_RESULT_OUT,
	output wire logic              O_SERIAL_RESULT_OE,
	// Front end and power status.
	output wire logic              O_TRACK,
	output wire logic              O_POWER_NAP,
	output wire logic              O_POWER_SLEEP,
	output wire logic              O_RESULT_READY,
	output wire logic              O_FRAME_ABORT
);

	localparam int SR_W   = CONV_W + 2;
	localparam int WAKE_W = $clog2(WAKE_SLEEP_CYC + 1);

	sar_port_pkg::pin_sample_t sel_n;
	sar_port_pkg::pin_sample_t sck;

	// Both pins idle high at reset so no false edge is seen at release.
	pin_edge_sync #(
		.RST_LEVEL (1'b1)
	) u_sel_sync (
		.i_clk (I_CORE_CLK),
		.i_rst (I_RST),
		.i_pin (I_FRAME_SEL_N),
		.o_pin (sel_n)
	);

	pin_edge_sync #(
		.RST_LEVEL (1'b1)
	) u_sck_sync (
		.i_clk (I_CORE_CLK),
		.i_rst (I_RST),
		.i_pin (I_SHIFT_CLK),
		.o_pin (sck)
	);

	// One successive-approximation step: resolve the bit at position CONV_W-1-idx, MSB first.
	function automatic logic [CONV_W-1:0] sar_step(
		input logic [CONV_W-1:0]     conv,
		input logic [CONV_W-1:0]     held,
		input logic [`EDGE_CNT_W-1:0] idx
	);
		logic [CONV_W-1:0] res;
		res = conv;
		res[CONV_W-1-int'(idx)] = held[CONV_W-1-int'(idx)];
		return res;
	endfunction : sar_step

	// Frame state.
	logic                   in_frame_q, in_frame_d;
	logic [`EDGE_CNT_W-1:0] edge_cnt_q, edge_cnt_d;
	logic [SR_W-1:0]        shift_q,    shift_d;
	logic                   oe_q,       oe_d;
	logic [CONV_W-1:0]      held_q,     held_d;
	logic [CONV_W-1:0]      conv_q,     conv_d;
	logic [CONV_W-1:0]      result_q,   result_d;
	logic                   abort_q,    abort_d;

	// A fall of the shift clock counts only inside an open frame, and a
	// fall that lands with the select fall is dropped: select goes first.
	logic step;
	assign step = sck.fall & in_frame_q & ~sel_n.fall;

	// Next values of the frame logic.
	always_comb begin
		in_frame_d = in_frame_q;
		edge_cnt_d = edge_cnt_q;
		shift_d    = shift_q;
		oe_d       = oe_q;
		held_d     = held_q;
		conv_d     = conv_q;
		result_d   = result_q;
		abort_d    = 1'b0;
		if (sel_n.fall) begin
			// RQ1 new conversion
			in_frame_d = 1'b1;
			edge_cnt_d = '0;
			held_d     = I_SAMPLE_CODE;
			conv_d     = '0;
			oe_d       = 1'b1;
			// RQ12 leading zero count
			if (sck.level) begin
				shift_d = {2'b00, result_q};
			end else begin
				shift_d = {1'b0, result_q, 1'b0};
			end
		end else if (sel_n.rise) begin
			// RQ3 release on select high
			in_frame_d = 1'b0;
			oe_d       = 1'b0;
			// RQ9 early rise aborts
			if (in_frame_q && edge_cnt_q >= `EDGE_CNT_W'(`LAST_CONV_EDGE)) begin
				// RQ7 one frame latency
				result_d = conv_q;
			end else begin
				abort_d = in_frame_q;
			end
		end else if (step && edge_cnt_q < `EDGE_CNT_W'(`FRAME_EDGES)) begin
			edge_cnt_d = edge_cnt_q + `EDGE_CNT_W'(1);
			// RQ4 step and shift
			if (edge_cnt_q < `EDGE_CNT_W'(`LAST_CONV_EDGE)) begin
				conv_d = sar_step(conv_q, held_q, edge_cnt_q);
			end
			// RQ13 trailing zeros
			shift_d = {shift_q[SR_W-2:0], 1'b0};
			// RQ8 release after sixteenth fall
			if (edge_cnt_q == `EDGE_CNT_W'(`FRAME_EDGES - 1)) begin
				oe_d = 1'b0;
			end
		end
	end

	// Frame registers.
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			in_frame_q <= 1'b0;
			edge_cnt_q <= '0;
			shift_q    <= '0;
			oe_q       <= 1'b0;
			held_q     <= '0;
			conv_q     <= '0;
			result_q   <= `RESULT_RST;
			abort_q    <= 1'b0;
		end else begin
			in_frame_q <= in_frame_d;
			edge_cnt_q <= edge_cnt_d;
			shift_q    <= shift_d;
			oe_q       <= oe_d;
			held_q     <= held_d;
			conv_q     <= conv_d;
			result_q   <= result_d;
			abort_q    <= abort_d;
		end
	end

	// Power state.
	sar_port_pkg::pwr_state_t pwr_q, pwr_d;
	logic [2:0]               pulses_q, pulses_d;
	logic                     clocked_q, clocked_d;
	logic [WAKE_W-1:0]        wake_q, wake_d;

	// Next values of the power logic. A frame with no shift-clock fall is
	// a control pulse; a frame that clocks wakes the core. The wake count
	// only flags results; nothing stalls, since the host owns the wait.
	always_comb begin
		pwr_d     = pwr_q;
		pulses_d  = pulses_q;
		clocked_d = clocked_q;
		wake_d    = wake_q;
		if (wake_q != '0) begin
			wake_d = wake_q - WAKE_W'(1);
		end
		if (sel_n.fall) begin
			clocked_d = 1'b0;
		end else if (step) begin
			clocked_d = 1'b1;
			pulses_d  = '0;
			// RQ11 sleep wake wait
			if (pwr_q == sar_port_pkg::PWR_SLEEP) begin
				wake_d = WAKE_W'(WAKE_SLEEP_CYC);
			// RQ10 nap wake wait
			end else if (pwr_q == sar_port_pkg::PWR_NAP) begin
				wake_d = WAKE_W'(WAKE_NAP_CYC);
			end
			pwr_d = sar_port_pkg::PWR_ACTIVE;
		end else if (sel_n.rise && in_frame_q && !clocked_q) begin
			if (pulses_q < `SLEEP_PULSES) begin
				pulses_d = pulses_q + 3'h1;
			end
			// RQ15 four pulses sleep
			if (pulses_q + 3'h1 >= `SLEEP_PULSES) begin
				pwr_d = sar_port_pkg::PWR_SLEEP;
			// RQ14 two pulses nap
			end else if (pulses_q + 3'h1 == `NAP_PULSES) begin
				pwr_d = sar_port_pkg::PWR_NAP;
			end
		end
	end

	// Power registers.
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			pwr_q     <= sar_port_pkg::PWR_ACTIVE;
			pulses_q  <= 3'h0;
			clocked_q <= 1'b0;
			wake_q    <= '0;
		end else begin
			pwr_q     <= pwr_d;
			pulses_q  <= pulses_d;
			clocked_q <= clocked_d;
			wake_q    <= wake_d;
		end
	end

	// RQ5 output from shift flop
	assign O_SERIAL_RESULT_OUT = shift_q[SR_W-1];
	assign O_SERIAL_RESULT_OE  = oe_q;
	// RQ2 tracking while select high
	assign O_TRACK        = ~in_frame_q;
	assign O_POWER_NAP    = (pwr_q == sar_port_pkg::PWR_NAP);
	assign O_POWER_SLEEP  = (pwr_q == sar_port_pkg::PWR_SLEEP);
	assign O_RESULT_READY = (pwr_q == sar_port_pkg::PWR_ACTIVE) &&
	                        (wake_q == '0);
	assign O_FRAME_ABORT  = abort_q;

endmodule : sar_readout_port

/* tb/host_model.sv */
module host_model (
	// Pacing clock and resolved data pin.
	input  wire logic i_clk,
	input  wire logic i_dat,
	// Frame select and shift clock pins.
	output logic      o_sel_n,
	output logic      o_sck
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pins rest high with no frame open.
	initial begin
		o_sel_n = 1'b1;
		o_sck   = 1'b1;
	end
	task automatic pause(input int n);
		repeat (n) @(posedge i_clk);
	endtask : pause
	// burst clock, idle level set per frame; a 400 ns shift period.
	task automatic frame(input logic hi, input int n, output logic [15:0] w);
		w = 16'h0000;
		o_sck <= hi;
		pause(8);
		o_sel_n <= 1'b0;
		pause(4);
		if (!hi) begin
			o_sck <= 1'b1;
			pause(4);
		end
		for (int i = 0; i < n; i++) begin
			o_sck <= 1'b0;
			pause(4);
			// bit taken at the rise, stable since the fall.
			w = {w[14:0], i_dat};
			o_sck <= 1'b1;
			pause(4);
		end
		// select rises after the n-th rise, past the fourteenth fall when n is 14 or more.
		o_sel_n <= 1'b1;
		pause(8);
	endtask : frame
endmodule : host_model

/* tb/port_asserts.sv */
module port_asserts (
	// Clock, reset and host pins.
	input wire logic I_CORE_CLK,
	input wire logic I_RST,
	input wire logic I_FRAME_SEL_N,
	input wire logic I_SHIFT_CLK,
	// Port outputs.
	input wire logic O_SERIAL_RESULT_OUT,
	input wire logic O_SERIAL_RESULT_OE,
	input wire logic O_TRACK,
	input wire logic O_POWER_NAP,
	input wire logic O_POWER_SLEEP,
	input wire logic O_FRAME_ABORT
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] cnt_q;
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RST);
	// Raw pin falls per frame, so a slip in the synchroniser shows up.
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			cnt_q <= 5'h00;
		end else begin
			cnt_q <= I_FRAME_SEL_N ? 5'h00 : cnt_q + 5'($fell(I_SHIFT_CLK));
		end
	end
	sequence s_open;
		$fell(I_FRAME_SEL_N) ##1 !I_FRAME_SEL_N [*2];
	endsequence
	a_frame_opens: assert property (
		s_open |=> ##[0:1] (O_SERIAL_RESULT_OE && !O_TRACK))
		else $error("frame did not open");
	a_idle_hiz: assert property (
		I_FRAME_SEL_N [*4] |-> !O_SERIAL_RESULT_OE)
		else $error("driven while idle");
	a_rise_tracks: assert property (
		$rose(I_FRAME_SEL_N) |-> ##[2:3] (O_TRACK && !O_SERIAL_RESULT_OE))
		else $error("no tracking");
	a_release_16: assert property (
		cnt_q == 5'h10 |-> ##[0:2] !O_SERIAL_RESULT_OE)
		else $error("no release");
	a_shift_on_fall: assert property (
		$changed(O_SERIAL_RESULT_OUT) && O_SERIAL_RESULT_OE &&
		$past(O_SERIAL_RESULT_OE) |->
		$past(I_SHIFT_CLK, 4) && !$past(I_SHIFT_CLK, 3))
		else $error("bit moved off a fall");
	a_abort_pulse: assert property (
		O_FRAME_ABORT |-> O_TRACK ##1 !O_FRAME_ABORT)
		else $error("bad abort");
	a_nap_entry: assert property (
		$rose(O_POWER_NAP) |-> O_TRACK && !O_POWER_SLEEP)
		else $error("bad nap");
	a_sleep_entry: assert property (
		$rose(O_POWER_SLEEP) |-> O_TRACK && !O_POWER_NAP)
		else $error("bad sleep");
endmodule : port_asserts

bind sar_readout_port port_asserts i_port_asserts (
	.I_CORE_CLK, .I_RST, .I_FRAME_SEL_N, .I_SHIFT_CLK, .O_SERIAL_RESULT_OUT,
	.O_SERIAL_RESULT_OE, .O_TRACK, .O_POWER_NAP, .O_POWER_SLEEP, .O_FRAME_ABORT
);

/* tb/sar_readout_port_bench.sv */
module sar_readout_port_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SLEEP_W = 20;
	localparam int NAP_W   = 1;
	logic        clk;
	logic        rst;
	logic [13:0] code;
	logic        sel_n;
	logic        sck;
	logic        dat;
	logic        oe;
	logic        last_q;
	logic        nap;
	logic        slp;
	logic        rdy;
	logic        abrt;
	logic [15:0] w;
	int          bad_count;
	int          cmp_count;
	int          cyc;
	int          aborts;
	int          lows;
	// A released line shows the inverse of its last driven level.
	wire logic   serial_result_out = oe ? dat : ~last_q;
	initial clk = 1'b0;
	always #25 clk = ~clk;
	sar_readout_port #(
		.WAKE_SLEEP_CYC(SLEEP_W),
		.WAKE_NAP_CYC  (NAP_W)
	) i_sar_readout_port (
		.I_CORE_CLK         (clk),
		.I_RST              (rst),
		.I_FRAME_SEL_N      (sel_n),
		.I_SHIFT_CLK        (sck),
		.I_SAMPLE_CODE      (code),
		.O_SERIAL_RESULT_OUT(dat),
		.O_SERIAL_RESULT_OE (oe),
		.O_TRACK            (),
		.O_POWER_NAP        (nap),
		.O_POWER_SLEEP      (slp),
		.O_RESULT_READY     (rdy),
		.O_FRAME_ABORT      (abrt)
	);
	host_model i_host_model (.i_clk(clk), .i_dat(serial_result_out), .o_sel_n(sel_n),
		.o_sck(sck));
	// Pulse counters and the hang limit. Ready low counts only while the
	// core is active, so the count holds the wake wait and nothing else.
	always @(posedge clk) begin
		cyc++;
		last_q <= (oe === 1'b1) ? dat : last_q;
		aborts += int'(abrt === 1'b1);
		lows += int'(rdy === 1'b0 && nap === 1'b0 && slp === 1'b0);
		if (cyc == 5000) begin
			bad_count++;
			results();
		end
	end
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [15:0] e, s);
		cmp_count++;
		if (s !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, s);
			bad_count++;
		end
	endtask : chk
	task automatic fr(input logic hi, input int n);
		i_host_model.frame(hi, n, w);
	endtask : fr
	// First frame returns the reset result, the next the first sample.
	task automatic t_latency();
		code <= 14'h2a5c;
		fr(1'b1, 15);
		chk("reset word", 16'h0000, w);
		code <= 14'h15a3;
		fr(1'b1, 15);
		chk("high idle", {2'b00, 14'h2a5c}, w);
	endtask : t_latency
	// Low idle clock gives one leading zero and a trailing zero.
	task automatic t_idle_low();
		code <= 14'h3c00;
		fr(1'b0, 15);
		chk("low idle", {1'b0, 14'h15a3, 1'b0}, w);
	endtask : t_idle_low
	// A short frame aborts and keeps the older result. The last bit of the
	// kept word is low, so a line released at the sixteenth fall reads high.
	task automatic t_abort();
		int a;
		a = aborts;
		code <= 14'h0f0f;
		fr(1'b1, 5);
		chk("abort", 16'(a + 1), 16'(aborts));
		fr(1'b1, 16);
		chk("kept", {1'b0, 14'h3c00, 1'b1}, w);
	endtask : t_abort
	// Static clock pulses enter nap then sleep; a shifted frame wakes.
	task automatic t_power();
		int l;
		repeat (2) fr(1'b1, 0);
		chk("nap", 16'h0001, {14'h0, slp, nap});
		l = lows;
		fr(1'b1, 15);
		chk("nap wake", 16'(l + NAP_W), 16'(lows));
		repeat (4) fr(1'b1, 0);
		chk("sleep", 16'h0002, {14'h0, slp, nap});
		l = lows;
		fr(1'b1, 15);
		chk("sleep wake", 16'(l + SLEEP_W), 16'(lows));
	endtask : t_power
	initial begin
		rst = 1'b1;
		code = 14'h0000;
		last_q = 1'b0;
		bad_count = 0;
		cmp_count = 0;
		cyc = 0;
		aborts = 0;
		lows = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_latency();
		t_idle_low();
		t_abort();
		t_power();
		results();
	end
endmodule : sar_readout_port_bench
